/* File: hdl/sprp_pkg.sv */
// Shared constants and types of the presence-detect EEPROM target
package sprp_pkg;
  localparam int          ADDR_W         = 8;
  localparam int          MEM_DEPTH      = 256;
  localparam int          FIFO_DEPTH     = 16;
  localparam int          LOWER_HALF_BIT = 7;
  localparam int          PIN_W          = 6;
  localparam int          PIN_SCL        = 5;
  localparam int          PIN_SDA        = 4;
  localparam int          PIN_GUARD      = 3;
  localparam int          PIN_HI         = 2;
  localparam int          PIN_MID        = 1;
  localparam int          PIN_LO         = 0;
  localparam logic [3:0]  PRE_ARRAY      = 4'ha;
  localparam logic [3:0]  PRE_LOCK       = 4'h6;
  localparam logic [2:0]  SEL_REV_SET    = 3'h1;
  localparam logic [2:0]  SEL_REV_CLR    = 3'h3;
  localparam logic [2:0]  BIT_FIRST      = 3'h0;
  localparam logic [2:0]  BIT_LAST       = 3'h7;
  localparam logic [7:0]  ADDR_RESET     = 8'h00;
  localparam logic [7:0]  ADDR_LAST      = 8'hff;
  localparam logic [7:0]  STATUS_FILL    = 8'hff;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [5:0]  PIN_RESET      = 6'h30;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } sprp_wr_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX   = 6'h02,
    ST_ACKW = 6'h04,
    ST_ACK  = 6'h08,
    ST_TX   = 6'h10,
    ST_HACK = 6'h20
  } sprp_state_t;

  typedef enum logic [3:0] {
    K_CTRL  = 4'h1,
    K_ADDR  = 4'h2,
    K_DATA  = 4'h4,
    K_LDATA = 4'h8
  } sprp_kind_t;
endpackage : sprp_pkg

/* File: hdl/sprp_fifo.sv */
// Parameterised valid/ready FIFO for queued array writes
module sprp_fifo
  import sprp_pkg::*;
#(
  parameter int W     = 16,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // Fill side
  input  wire logic         inValid,
  output logic              inReady,
  input  wire logic [W-1:0] inData,
  // Drain side
  output logic              outValid,
  input  wire logic         outReady,
  output logic [W-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] store [DEPTH];
  logic [AW:0]  wrPtr_ff;
  logic [AW:0]  rdPtr_ff;
  logic         doPush;
  logic         doPop;

  assign inReady  = (wrPtr_ff[AW] == rdPtr_ff[AW]) ||
                    (wrPtr_ff[AW-1:0] != rdPtr_ff[AW-1:0]);
  assign outValid = (wrPtr_ff != rdPtr_ff);
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;
  assign outData  = store[rdPtr_ff[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (doPush) begin
      store[wrPtr_ff[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wrPtr_ff <= '0;
    end else if (doPush) begin
      wrPtr_ff <= wrPtr_ff + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdPtr_ff <= '0;
    end else if (doPop) begin
      rdPtr_ff <= rdPtr_ff + 1'b1;
    end
  end
endmodule : sprp_fifo

/* File: hdl/sprp_array.sv */
// Byte array with registered read data, one access per cycle
module sprp_array
  import sprp_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH,
  parameter int AW    = ADDR_W
) (
  // Clock
  input  wire logic          ref_clk,
  // Read port, takes priority
  input  wire logic          rdEn,
  input  wire logic [AW-1:0] rdAddr,
  output logic [7:0]         rdData,
  // Write port
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [7:0]    wrData
);
  logic [7:0] cells [DEPTH];

  always_ff @(posedge ref_clk) begin
    if (rdEn) begin
      rdData <= cells[rdAddr];
    end else if (wrEn) begin
      cells[wrAddr] <= wrData;
    end
  end
endmodule : sprp_array

/* File: hdl/sprp_spd_target.sv */
// Two-wire presence-detect EEPROM target: reads, lock status, write guard
// Summary of operation
// - Write-guard pin high refuses every array write and all lock programming
// - Guard high: array commands acked, reads served, write data not acked
// - Guard high, permanent clear: lock command acked, its data byte refused
// - Permanent lock set: lock set/clear commands and data never acked
// - Reversible lock set: set-reversible command and data not acked
// - Permanent status read acked only while permanent lock is clear
// - Reversible status read acked only while reversible lock is clear
// - Permanent status query: preamble 0110, strap bits, direction one
// - Reversible status query: preamble 0110, bits 001, direction one
// - Read starts like write but direction bit one; device sends data
// - Word counter holds last accessed address plus one, kept between ops
// - Counter wraps from last byte to first byte, reading continues
// - After acked read address, current byte shifts out MSB first
// - Each host acknowledge sends next byte; only in an array read does it also advance the address
// - Once permanent lock is programmed it stays set until reset
module sprp_spd_target
  import sprp_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Two-wire bus pins
  input  wire logic       sclPin,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOeN,
  // Strap and guard pins
  input  wire logic       writeGuardPin,
  input  wire logic       strapAddrHi,
  input  wire logic       strapAddrMid,
  input  wire logic       strapAddrLo,
  // Lock cells from the nonvolatile store
  input  wire logic       permanentLowerLock,
  input  wire logic       reversibleLowerLock,
  // Status
  output logic [7:0]      wordAddr,
  output logic            permLockActive
);
  logic [PIN_W-1:0] pinMeta_ff;
  logic [PIN_W-1:0] pinSync_ff;
  logic             sclPrev_ff;
  logic             sdaPrev_ff;
  sprp_state_t      state_ff;
  sprp_kind_t       kind_ff;
  logic [2:0]       bitCnt_ff;
  logic [7:0]       rxShift_ff;
  logic [7:0]       txShift_ff;
  logic             sdaLow_ff;
  logic             ackBit_ff;
  logic             readMode_ff;
  logic             arrayMode_ff;
  logic             hostAck_ff;
  logic [7:0]       addr_ff;
  logic             permLatched_ff;

  logic       sclS, sdaS, guardS;
  logic [2:0] straps;
  logic       sclRise, sclFall, startCond, stopCond;
  logic [7:0] byteIn;
  logic       isArray, isLockP, isRevSet, isRevClr, rw, lockCmdW;
  logic       rxDone, ackNow, txLoad, rdReq, revLock;
  logic       fifoReady, fifoPush, drainValid, drainReady;
  sprp_wr_t   pushWord, drainWord;
  logic [7:0] memData;

  // Every pin passes two flops; edge logic reads only the second stage
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pinMeta_ff <= PIN_RESET;
      pinSync_ff <= PIN_RESET;
    end else begin
      pinMeta_ff <= {sclPin, sdaIn, writeGuardPin,
                     strapAddrHi, strapAddrMid, strapAddrLo};
      pinSync_ff <= pinMeta_ff;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
    end else begin
      sclPrev_ff <= sclS;
      sdaPrev_ff <= sdaS;
    end
  end

  assign sclS      = pinSync_ff[PIN_SCL];
  assign sdaS      = pinSync_ff[PIN_SDA];
  assign guardS    = pinSync_ff[PIN_GUARD];
  assign straps    = {pinSync_ff[PIN_HI], pinSync_ff[PIN_MID],
                      pinSync_ff[PIN_LO]};
  assign sclRise   = sclS && !sclPrev_ff;
  assign sclFall   = !sclS && sclPrev_ff;
  assign startCond = sclS && sclPrev_ff && sdaPrev_ff && !sdaS;
  assign stopCond  = sclS && sclPrev_ff && !sdaPrev_ff && sdaS;
  assign revLock   = reversibleLowerLock;

  // Lock stays set until reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      permLatched_ff <= 1'b0;
    end else begin
      permLatched_ff <= permLatched_ff | permanentLowerLock;
    end
  end

  // Command decode of the byte completing on this rising edge
  assign byteIn   = {rxShift_ff[6:0], sdaS};
  assign rw       = byteIn[0];
  assign isArray  = (byteIn[7:4] == PRE_ARRAY) && (byteIn[3:1] == straps);
  assign isLockP  = (byteIn[7:4] == PRE_LOCK) && (byteIn[3:1] == straps);
  assign isRevSet = (byteIn[7:4] == PRE_LOCK) && !isLockP &&
                    (byteIn[3:1] == SEL_REV_SET);
  assign isRevClr = (byteIn[7:4] == PRE_LOCK) && !isLockP &&
                    (byteIn[3:1] == SEL_REV_CLR);
  assign lockCmdW = !rw && (isLockP || isRevSet || isRevClr);
  assign rxDone   = (state_ff == ST_RX) && sclRise && !startCond &&
                    !stopCond && (bitCnt_ff == BIT_LAST);

  always_comb begin
    ackNow = 1'b0;
    case (kind_ff)
      K_CTRL: begin
        if (isArray) begin
          ackNow = 1'b1;
        end else if (isLockP) begin
          ackNow = !permLatched_ff;
        end else if (isRevSet && rw) begin
          ackNow = !revLock;
        end else if (isRevSet) begin
          ackNow = !permLatched_ff && !revLock;
        end else if (isRevClr) begin
          ackNow = !rw && !permLatched_ff;
        end
      end
      K_ADDR: ackNow = 1'b1;
      // Queue full also refuses, so a stalled drain never loses a byte
      K_DATA: ackNow = !guardS && fifoReady &&
                       !(!addr_ff[LOWER_HALF_BIT] &&
                         (permLatched_ff || revLock));
      K_LDATA: ackNow = !guardS;
      default: ackNow = 1'b0;
    endcase
  end

  // Lock data is acknowledged only while the guard pin is low, and never programs a cell here
  assign fifoPush = rxDone && (kind_ff == K_DATA) && ackNow;
  assign pushWord = '{addr: addr_ff, data: byteIn};
  assign txLoad   = sclFall && !startCond && !stopCond &&
                    (((state_ff == ST_ACK) && ackBit_ff && readMode_ff) ||
                     ((state_ff == ST_HACK) && hostAck_ff));
  assign rdReq    = (rxDone && (kind_ff == K_CTRL) && isArray && rw) ||
                    ((state_ff == ST_HACK) && sclRise && !sdaS &&
                     arrayMode_ff);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff  <= ST_IDLE;
      kind_ff   <= K_CTRL;
      bitCnt_ff <= BIT_FIRST;
      sdaLow_ff <= 1'b0;
    end else if (startCond) begin
      state_ff  <= ST_RX;
      kind_ff   <= K_CTRL;
      bitCnt_ff <= BIT_FIRST;
      sdaLow_ff <= 1'b0;
    end else if (stopCond) begin
      state_ff  <= ST_IDLE;
      sdaLow_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: sdaLow_ff <= 1'b0;
        ST_RX: begin
          if (rxDone) begin
            state_ff <= ST_ACKW;
          end else if (sclRise) begin
            bitCnt_ff <= bitCnt_ff + 1'b1;
          end
        end
        ST_ACKW: begin
          if (sclFall) begin
            sdaLow_ff <= ackBit_ff;
            state_ff  <= ST_ACK;
          end
        end
        ST_ACK: begin
          if (sclFall) begin
            bitCnt_ff <= BIT_FIRST;
            if (!ackBit_ff) begin
              sdaLow_ff <= 1'b0;
              state_ff  <= ST_IDLE;
            end else if (readMode_ff) begin
              sdaLow_ff <= !(arrayMode_ff ? memData[7] : STATUS_FILL[7]);
              state_ff  <= ST_TX;
            end else begin
              sdaLow_ff <= 1'b0;
              state_ff  <= ST_RX;
              kind_ff   <= (kind_ff == K_CTRL) ?
                           (arrayMode_ff ? K_ADDR : K_LDATA) :
                           ((kind_ff == K_LDATA) ? K_LDATA : K_DATA);
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (bitCnt_ff == BIT_LAST) begin
              sdaLow_ff <= 1'b0;
              state_ff  <= ST_HACK;
            end else begin
              bitCnt_ff <= bitCnt_ff + 1'b1;
              sdaLow_ff <= !txShift_ff[6];
            end
          end
        end
        ST_HACK: begin
          if (sclRise && sdaS) begin
            state_ff <= ST_IDLE;
          end else if (txLoad) begin
            bitCnt_ff <= BIT_FIRST;
            sdaLow_ff <= !(arrayMode_ff ? memData[7] : STATUS_FILL[7]);
            state_ff  <= ST_TX;
          end
        end
        default: begin
          state_ff  <= ST_IDLE;
          sdaLow_ff <= 1'b0;
        end
      endcase
    end
  end

  // Control byte kind is kept until the next control byte
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rxShift_ff   <= BYTE_RESET;
      ackBit_ff    <= 1'b0;
      readMode_ff  <= 1'b0;
      arrayMode_ff <= 1'b0;
    end else if ((state_ff == ST_RX) && sclRise) begin
      rxShift_ff <= byteIn;
      if (rxDone) begin
        ackBit_ff <= ackNow;
        if (kind_ff == K_CTRL) begin
          readMode_ff  <= rw;
          arrayMode_ff <= isArray;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hostAck_ff <= 1'b0;
    end else if (state_ff != ST_HACK) begin
      hostAck_ff <= 1'b0;
    end else if (sclRise) begin
      hostAck_ff <= !sdaS;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      txShift_ff <= STATUS_FILL;
    end else if (txLoad) begin
      txShift_ff <= arrayMode_ff ? memData : STATUS_FILL;
    end else if ((state_ff == ST_TX) && sclFall) begin
      txShift_ff <= {txShift_ff[6:0], 1'b1};
    end
  end

  // Word counter survives stops and repeated starts
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      addr_ff <= ADDR_RESET;
    end else if (rxDone && (kind_ff == K_ADDR)) begin
      addr_ff <= byteIn;
    end else if (fifoPush || (txLoad && arrayMode_ff)) begin
      addr_ff <= (addr_ff == ADDR_LAST) ? ADDR_RESET :
                 addr_ff + 1'b1;
    end
  end

  // Reads own the array port; queued writes wait behind them
  assign drainReady = !rdReq;

  sprp_fifo #(
    .W     ($bits(sprp_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .inValid  (fifoPush),
    .inReady  (fifoReady),
    .inData   (pushWord),
    .outValid (drainValid),
    .outReady (drainReady),
    .outData  (drainWord)
  );

  sprp_array #(
    .DEPTH (MEM_DEPTH),
    .AW    (ADDR_W)
  ) u_array (
    .ref_clk (ref_clk),
    .rdEn    (rdReq),
    .rdAddr  (addr_ff),
    .rdData  (memData),
    .wrEn    (drainValid),
    .wrAddr  (drainWord.addr),
    .wrData  (drainWord.data)
  );

  assign sdaOut         = 1'b0;
  assign sdaOeN         = !sdaLow_ff;
  assign wordAddr       = addr_ff;
  assign permLockActive = permLatched_ff;

  sequence s_hostAck;
    (state_ff == ST_HACK) && sclRise && !sdaS && !startCond;
  endsequence

  sequence s_nextByte;
    ##[1:64] ((state_ff == ST_TX) && (bitCnt_ff == BIT_FIRST));
  endsequence

  property p_guard_no_store;
    @(posedge ref_clk) disable iff (reset)
      guardS && rxDone && (kind_ff == K_DATA)
      |-> !fifoPush ##1 !ackBit_ff;
  endproperty
  a_guard_no_store: assert property (p_guard_no_store)
    else $error("array write queued while guard high");

  property p_lock_data_nack;
    @(posedge ref_clk) disable iff (reset)
      rxDone && (kind_ff == K_LDATA) && guardS |=> !ackBit_ff;
  endproperty
  a_lock_data_nack: assert property (p_lock_data_nack)
    else $error("lock data acked under guard");

  property p_perm_lock_nack;
    @(posedge ref_clk) disable iff (reset)
      rxDone && (kind_ff == K_CTRL) && lockCmdW && permLatched_ff
      |=> !ackBit_ff;
  endproperty
  a_perm_lock_nack: assert property (p_perm_lock_nack)
    else $error("lock command acked with permanent lock set");

  property p_rev_set_nack;
    @(posedge ref_clk) disable iff (reset)
      rxDone && (kind_ff == K_CTRL) && isRevSet && !rw && revLock
      |=> !ackBit_ff;
  endproperty
  a_rev_set_nack: assert property (p_rev_set_nack)
    else $error("set-reversible acked with lock set");

  property p_perm_status;
    @(posedge ref_clk) disable iff (reset)
      rxDone && (kind_ff == K_CTRL) && isLockP && rw
      |=> (ackBit_ff == !$past(permLatched_ff));
  endproperty
  a_perm_status: assert property (p_perm_status)
    else $error("permanent status ack wrong");

  property p_rev_status;
    @(posedge ref_clk) disable iff (reset)
      rxDone && (kind_ff == K_CTRL) && isRevSet && rw
      |=> (ackBit_ff == !$past(revLock));
  endproperty
  a_rev_status: assert property (p_rev_status)
    else $error("reversible status ack wrong");

  property p_counter_step;
    @(posedge ref_clk) disable iff (reset)
      txLoad && arrayMode_ff && !rdReq
      |=> (addr_ff == 8'(($past(addr_ff) + 9'h001) % 9'h100));
  endproperty
  a_counter_step: assert property (p_counter_step)
    else $error("word counter did not step or wrap");

  property p_perm_sticky;
    @(posedge ref_clk) disable iff (reset)
      permLatched_ff |=> permLatched_ff [*8];
  endproperty
  a_perm_sticky: assert property (p_perm_sticky)
    else $error("permanent lock cleared");

  property p_release_one;
    @(posedge ref_clk) disable iff (reset)
      (state_ff == ST_TX) |-> (sdaOeN == txShift_ff[7]);
  endproperty
  a_release_one: assert property (p_release_one)
    else $error("data line driven while sending one");

  property p_seq_next;
    @(posedge ref_clk) disable iff (reset)
      s_hostAck |-> s_nextByte;
  endproperty
  a_seq_next: assert property (p_seq_next)
    else $error("next byte not started after host ack");
endmodule : sprp_spd_target

/* File: tb/sprp_host_model.sv */
// Behavioural two-wire bus host: makes the link clock, open-drain data
module sprp_host_model (
  // Bus lines
  output logic      sclLine,
  output logic      hostOeN,
  input  wire logic sdaWire
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    sclLine = 1'b1;
    hostOeN = 1'b1;
  end

  // Data moves 120 ns after the fall, so the target's hold need is met
  task automatic put_bit(input logic b, output logic r);
    #120 hostOeN = b;
    #40 sclLine = 1'b1;
    #80 r = sdaWire;
    #80 sclLine = 1'b0;
  endtask : put_bit

  task automatic bus_start();
    #120 hostOeN = 1'b1;
    #40 sclLine = 1'b1;
    #80 hostOeN = 1'b0;
    #80 sclLine = 1'b0;
  endtask : bus_start

  // Clock stands high after this, no free-running link clock
  task automatic bus_stop();
    #120 hostOeN = 1'b0;
    #40 sclLine = 1'b1;
    #80 hostOeN = 1'b1;
    #80;
  endtask : bus_stop

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r);
    put_bit(1'b1, r);
    ack = ~r;
  endtask : send_byte

  task automatic recv_byte(input logic ackIt, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, r);
      d[i] = r;
    end
    put_bit(~ackIt, r);
  endtask : recv_byte
endmodule : sprp_host_model

/* File: tb/sprp_spd_target_tb.sv */
// Self-checking bench of the presence-detect EEPROM target
module sprp_spd_target_tb
  import sprp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [2:0] STRAP     = 3'h5;
  localparam logic [7:0] WR_CTRL   = {PRE_ARRAY, STRAP, 1'b0};
  localparam logic [7:0] RD_CTRL   = {PRE_ARRAY, STRAP, 1'b1};
  localparam logic [7:0] PERM_SET  = {PRE_LOCK, STRAP, 1'b0};
  localparam logic [7:0] PERM_STAT = {PRE_LOCK, STRAP, 1'b1};
  localparam logic [7:0] REV_SET   = {PRE_LOCK, SEL_REV_SET, 1'b0};
  localparam logic [7:0] REV_CLR   = {PRE_LOCK, SEL_REV_CLR, 1'b0};
  localparam logic [7:0] REV_STAT  = {PRE_LOCK, SEL_REV_SET, 1'b1};
  localparam logic [7:0] PAT [4]   = '{8'h3c, 8'hc5, 8'h81, 8'h7e};

  logic       refClk = 1'b0;
  logic       reset;
  logic       guard;
  logic [2:0] strap;
  logic       permLock;
  logic       revLock;
  logic       sclLine;
  logic       hostOeN;
  logic       sdaOut;
  logic       sdaOeN;
  logic [7:0] wordAddr;
  logic       permLockActive;
  logic       ack;
  logic [7:0] rd;
  wire  logic sdaWire;
  int         errors;
  int         cmpCount;

  // Pull-up wins unless a party pulls low
  assign sdaWire = (hostOeN & sdaOeN) ? 1'b1 : 1'b0;
  always #20 refClk = ~refClk;

  sprp_spd_target uut (
    .ref_clk(refClk), .reset(reset), .sclPin(sclLine), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOeN(sdaOeN), .writeGuardPin(guard),
    .strapAddrHi(strap[2]), .strapAddrMid(strap[1]),
    .strapAddrLo(strap[0]), .permanentLowerLock(permLock),
    .reversibleLowerLock(revLock), .wordAddr(wordAddr),
    .permLockActive(permLockActive)
  );

  sprp_host_model host (
    .sclLine(sclLine), .hostOeN(hostOeN), .sdaWire(sdaWire)
  );

  task automatic give_verdict();
    $display("errors=%0d comparisons=%0d", errors, cmpCount);
    if (errors == 0 && cmpCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Frame opens off the clock grid so link edges never race the sampler
  task automatic cmd(input logic [7:0] c, input logic expAck);
    @(posedge refClk);
    #13 host.bus_start();
    host.send_byte(c, ack);
    check({7'h00, ack}, {7'h00, expAck});
  endtask : cmd

  task automatic wr(input logic [7:0] d, input logic expAck);
    host.send_byte(d, ack);
    check({7'h00, ack}, {7'h00, expAck});
  endtask : wr

  task automatic rd_chk(input logic more, input logic [7:0] exp);
    host.recv_byte(more, rd);
    check(rd, exp);
  endtask : rd_chk

  // Lock or status frame; any data after an ack is refused or ignored
  task automatic req(input logic [7:0] c, input logic expAck);
    cmd(c, expAck);
    if (expAck && c[0]) host.recv_byte(1'b0, rd);
    else if (expAck) wr(8'ha5, 1'b0);
    host.bus_stop();
  endtask : req

  always @(negedge refClk)
    if (!reset && sdaOeN === 1'b0) check({7'h00, sdaOut}, 8'h00);

  initial begin
    #1000000;
    errors++;
    give_verdict();
  end

  initial begin
    errors = 0;
    cmpCount = 0;
    reset = 1'b1;
    guard = 1'b0;
    strap = STRAP;
    permLock = 1'b0;
    revLock = 1'b0;
    repeat (10) @(posedge refClk);
    reset <= 1'b0;
    repeat (4) @(posedge refClk);
    #13 check(wordAddr, 8'h00);
    cmd(WR_CTRL, 1'b1);
    wr(8'hfe, 1'b1);
    for (int i = 0; i < 4; i++) wr(PAT[i], 1'b1);
    host.bus_stop();
    check(wordAddr, 8'h02);
    cmd(WR_CTRL, 1'b1);
    wr(8'hfe, 1'b1);
    cmd(RD_CTRL, 1'b1);
    for (int i = 0; i < 2; i++) rd_chk(1'b1, PAT[i]);
    rd_chk(1'b0, PAT[2]);
    host.bus_stop();
    check(wordAddr, 8'h01);
    cmd(RD_CTRL, 1'b1);
    rd_chk(1'b0, PAT[3]);
    host.bus_stop();
    @(posedge refClk);
    guard <= 1'b1;
    cmd(WR_CTRL, 1'b1);
    wr(8'h01, 1'b1);
    wr(8'h5a, 1'b0);
    host.bus_stop();
    check(wordAddr, 8'h01);
    cmd(RD_CTRL, 1'b1);
    rd_chk(1'b0, PAT[3]);
    host.bus_stop();
    req(PERM_SET, 1'b1);
    req(REV_SET, 1'b1);
    req(REV_CLR, 1'b1);
    @(posedge refClk);
    revLock <= 1'b1;
    req(REV_SET, 1'b0);
    req(REV_CLR, 1'b1);
    req(REV_STAT, 1'b0);
    @(posedge refClk);
    revLock <= 1'b0;
    req(REV_STAT, 1'b1);
    req(PERM_STAT, 1'b1);
    @(posedge refClk);
    guard <= 1'b0;
    cmd(REV_CLR, 1'b1);
    wr(8'ha5, 1'b1);
    host.bus_stop();
    @(posedge refClk);
    permLock <= 1'b1;
    req(PERM_STAT, 1'b0);
    req(PERM_SET, 1'b0);
    req(REV_SET, 1'b0);
    req(REV_CLR, 1'b0);
    @(posedge refClk);
    permLock <= 1'b0;
    req(PERM_STAT, 1'b0);
    check({7'h00, permLockActive}, 8'h01);
    cmd(WR_CTRL, 1'b1);
    wr(8'h01, 1'b1);
    wr(8'h5a, 1'b0);
    host.bus_stop();
    cmd(WR_CTRL, 1'b1);
    wr(8'h01, 1'b1);
    cmd(RD_CTRL, 1'b1);
    rd_chk(1'b0, PAT[3]);
    host.bus_stop();
    cmd(WR_CTRL, 1'b1);
    wr(8'h80, 1'b1);
    wr(8'h5a, 1'b1);
    host.bus_stop();
    check(wordAddr, 8'h81);
    give_verdict();
  end
endmodule : sprp_spd_target_tb
